/* File: hdl/rtcu_irq.sv */
// Update and alarm interrupt logic of the clock with its APB register file
//
// Contract
// - Period select: 0 each second, 1 each minute
// - Update event sets update flag until cleared
// - Update flag clear keeps active output low
// - Writing 1 to flags changes nothing
// - Update enable drives low, auto release 7.8ms
// - Update enable off: no low, releases
// - Disabled source never blocks other sources
// - Alarm fires when minute, hour, day match
// - Alarm fires only on counter advance
// - Alarm flag holds one until written zero
// - Alarm enable holds output low until cleared
// - Alarm enable cleared releases output immediately
// - Alarm flag cleared releases output immediately
// - Alarm enable off: flag set, output released
// - Control reset bit suppresses alarm events
// - Unused count, flag bits read zero; control bits 2:1 read zero, bits 7, 6, 4 hold writes
// - Select 0 compares weekday, 1 compares date
// - Bit seven of alarm register disables compare
// - Weekday field is mask; any day matches
// - All compares disabled: alarm every minute
// - Undefined alarm bits are plain storage
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

module rtcu_irq #(
    parameter int unsigned ADDR_WIDTH = 12,
    parameter int unsigned RELEASE_CYCLES = rtcu_pkg::INT_RELEASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rtcu_pkg::rtcu_time_t time_now,
    input wire rtcu_pkg::rtcu_tick_t time_tick,
    output logic int_o,
    output logic int_oe_n
);
    import rtcu_pkg::*;

    localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);
    localparam logic [CNT_W-1:0] RELEASE_LAST =
        CNT_W'(RELEASE_CYCLES - 1);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin : g_bad_addr
        $error("ADDR_WIDTH must lie between 6 and 32");
    end
    if (RELEASE_CYCLES < 1) begin : g_bad_release
        $error("RELEASE_CYCLES must be at least 1");
    end

    // ==========================================================
    // Functions
    // ==========================================================
    // True when the address hits a mapped register word
    function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] a);
        logic [3:0] idx;
        logic hi_zero;
        idx = a[5:2];
        hi_zero = (a >> 6) == '0;
        addr_mapped = hi_zero && (a[1:0] == 2'b00) &&
            (idx == IDX_MINUTES_COUNT || idx == IDX_HOURS_COUNT ||
             idx == IDX_WEEKDAY_COUNT || idx == IDX_DATE_COUNT ||
             idx == IDX_ALARM_MINUTE || idx == IDX_ALARM_HOUR ||
             idx == IDX_ALARM_WEEKDAY_OR_DATE ||
             idx == IDX_EXTENSION_CONFIG || idx == IDX_EVENT_FLAGS ||
             idx == IDX_INTERRUPT_CONTROL);
    endfunction

    // One field compare, skipped when its disable bit is set
    function automatic logic field_ok(input logic [7:0] alarm,
                                      input logic [6:0] now);
        field_ok = alarm[BIT_ALARM_COMPARE_DISABLE] ||
            (alarm[6:0] == now);
    endfunction

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] alarm_minute_reg;
    logic [7:0] alarm_hour_reg;
    logic [7:0] alarm_weekday_or_date_reg;
    logic [7:0] extension_config_reg;
    logic [7:0] interrupt_control_reg;
    logic update_event_flag_reg;
    logic alarm_event_flag_reg;
    logic update_low_reg;
    logic alarm_low_reg;
    logic [CNT_W-1:0] release_cnt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic int_oe_n_reg;
    logic int_o_reg;

    // ==========================================================
    // Bus decode
    // ==========================================================
    logic setup_phase;
    logic wr_commit;
    logic [3:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_ok;

    assign setup_phase = psel && !penable;
    assign wr_commit = psel && penable && pready_reg && pwrite;
    assign wr_idx = paddr[5:2];
    assign wr_byte = pwdata[7:0];
    assign wr_ok = wr_commit && pstrb[0] && addr_mapped(paddr);

    logic wr_alarm_minute;
    logic wr_alarm_hour;
    logic wr_alarm_day;
    logic wr_extension;
    logic wr_flags;
    logic wr_control;

    assign wr_alarm_minute = wr_ok && (wr_idx == IDX_ALARM_MINUTE);
    assign wr_alarm_hour = wr_ok && (wr_idx == IDX_ALARM_HOUR);
    assign wr_alarm_day = wr_ok && (wr_idx == IDX_ALARM_WEEKDAY_OR_DATE);
    assign wr_extension = wr_ok && (wr_idx == IDX_EXTENSION_CONFIG);
    assign wr_flags = wr_ok && (wr_idx == IDX_EVENT_FLAGS);
    assign wr_control = wr_ok && (wr_idx == IDX_INTERRUPT_CONTROL);

    // ==========================================================
    // Control fields
    // ==========================================================
    logic update_period_select;
    logic week_or_date_select;
    logic update_irq_enable;
    logic alarm_irq_enable;
    logic ctrl_reset;

    assign update_period_select =
        extension_config_reg[BIT_UPDATE_PERIOD_SELECT];
    assign week_or_date_select =
        extension_config_reg[BIT_WEEK_OR_DATE_SELECT];
    assign update_irq_enable = interrupt_control_reg[BIT_UPDATE_IRQ_ENABLE];
    assign alarm_irq_enable = interrupt_control_reg[BIT_ALARM_IRQ_ENABLE];
    assign ctrl_reset = interrupt_control_reg[BIT_CTRL_RESET];

    // Enables as they stand after a control write in this cycle
    logic update_en_next;
    logic alarm_en_next;

    assign update_en_next = wr_control ? wr_byte[BIT_UPDATE_IRQ_ENABLE] :
        update_irq_enable;
    assign alarm_en_next = wr_control ? wr_byte[BIT_ALARM_IRQ_ENABLE] :
        alarm_irq_enable;

    // ==========================================================
    // Events
    // ==========================================================
    logic update_event;
    logic day_ok;
    logic alarm_match;
    logic alarm_event;

    // Counter update also stops while the reset bit is set
    assign update_event = !ctrl_reset && (update_period_select ?
        time_tick.minute_tick : time_tick.second_tick);

    // Weekday field is a mask of days; date compared as BCD
    always_comb begin
        if (alarm_weekday_or_date_reg[BIT_ALARM_COMPARE_DISABLE]) begin
            day_ok = 1'b1;
        end else if (week_or_date_select) begin
            day_ok = alarm_weekday_or_date_reg[5:0] == time_now.date;
        end else begin
            day_ok = (alarm_weekday_or_date_reg[6:0] &
                time_now.weekday) != 7'h00;
        end
    end

    // All three disables set leave only the minute tick
    assign alarm_match = field_ok(alarm_minute_reg, time_now.minute) &&
        field_ok({alarm_hour_reg[7], 1'b0, alarm_hour_reg[5:0]},
            {1'b0, time_now.hour}) && day_ok;

    // Checked only as the counters step into a new minute
    assign alarm_event = time_tick.minute_tick && alarm_match &&
        !ctrl_reset;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_minute_reg <= ALARM_RESET_VALUE;
            alarm_hour_reg <= ALARM_RESET_VALUE;
            alarm_weekday_or_date_reg <= ALARM_RESET_VALUE;
        end else begin
            // Unassigned bits hold whatever is written
            if (wr_alarm_minute) begin
                alarm_minute_reg <= wr_byte;
            end
            if (wr_alarm_hour) begin
                alarm_hour_reg <= wr_byte;
            end
            if (wr_alarm_day) begin
                alarm_weekday_or_date_reg <= wr_byte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extension_config_reg <= EXTENSION_RESET_VALUE;
            interrupt_control_reg <= CONTROL_RESET_VALUE;
        end else begin
            if (wr_extension) begin
                extension_config_reg <= wr_byte;
            end
            if (wr_control) begin
                interrupt_control_reg <= wr_byte & CTRL_WRITE_MASK;
            end
        end
    end

    // ==========================================================
    // Event flags: a new event wins over a clear
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_event_flag_reg <= 1'b0;
            alarm_event_flag_reg <= 1'b0;
        end else begin
            if (update_event) begin
                update_event_flag_reg <= 1'b1;
            end else if (wr_flags && !wr_byte[BIT_UPDATE_EVENT_FLAG]) begin
                update_event_flag_reg <= 1'b0;
            end
            if (alarm_event) begin
                alarm_event_flag_reg <= 1'b1;
            end else if (wr_flags && !wr_byte[BIT_ALARM_EVENT_FLAG]) begin
                alarm_event_flag_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Update interrupt request with automatic release
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_low_reg <= 1'b0;
            release_cnt_reg <= '0;
        end else begin
            // Flag clears are ignored here on purpose
            if (update_event && update_en_next) begin
                update_low_reg <= 1'b1;
                release_cnt_reg <= '0;
            end else if (!update_en_next) begin
                update_low_reg <= 1'b0;
                release_cnt_reg <= '0;
            end else if (update_low_reg) begin
                if (release_cnt_reg == RELEASE_LAST) begin
                    update_low_reg <= 1'b0;
                    release_cnt_reg <= '0;
                end else begin
                    release_cnt_reg <= release_cnt_reg + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Alarm interrupt request, held until flag or enable clears
    // ==========================================================
    logic alarm_flag_clear;

    assign alarm_flag_clear = wr_flags && !wr_byte[BIT_ALARM_EVENT_FLAG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_low_reg <= 1'b0;
        end else begin
            if (alarm_event) begin
                alarm_low_reg <= alarm_en_next;
            end else if (!alarm_en_next) begin
                alarm_low_reg <= 1'b0;
            end else if (alarm_flag_clear) begin
                alarm_low_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Shared open-drain pin
    // ==========================================================
    logic int_low_next;

    // Each request already carries its own enable, so a disabled
    // source simply contributes nothing
    assign int_low_next = (update_low_reg && update_irq_enable) ||
        (alarm_low_reg && alarm_irq_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_oe_n_reg <= 1'b1;
            int_o_reg <= 1'b0;
        end else begin
            int_oe_n_reg <= !int_low_next;
            int_o_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    logic [7:0] rd_byte;

    always_comb begin
        unique case (paddr[5:2])
            IDX_MINUTES_COUNT: rd_byte = {1'b0, time_now.minute};
            IDX_HOURS_COUNT: rd_byte = {2'b00, time_now.hour};
            IDX_WEEKDAY_COUNT: rd_byte = {1'b0, time_now.weekday};
            IDX_DATE_COUNT: rd_byte = {2'b00, time_now.date};
            IDX_ALARM_MINUTE: rd_byte = alarm_minute_reg;
            IDX_ALARM_HOUR: rd_byte = alarm_hour_reg;
            IDX_ALARM_WEEKDAY_OR_DATE: rd_byte = alarm_weekday_or_date_reg;
            IDX_EXTENSION_CONFIG: rd_byte = extension_config_reg;
            IDX_EVENT_FLAGS: begin
                rd_byte = 8'h00;
                rd_byte[BIT_UPDATE_EVENT_FLAG] = update_event_flag_reg;
                rd_byte[BIT_ALARM_EVENT_FLAG] = alarm_event_flag_reg;
            end
            IDX_INTERRUPT_CONTROL: rd_byte = interrupt_control_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // APB answer: one wait-free access phase after each setup
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup_phase;
            if (setup_phase) begin
                pslverr_reg <= !addr_mapped(paddr);
                prdata_reg <= (!pwrite && addr_mapped(paddr)) ?
                    {24'h00_0000, rd_byte} : 32'h0000_0000;
            end else begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign int_o = int_o_reg;
    assign int_oe_n = int_oe_n_reg;

endmodule

/* File: hdl/rtcu_pkg.sv */
// Package: register map, field layout, timing constants and carrier types
package rtcu_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [3:0] IDX_MINUTES_COUNT = 4'h1;
    localparam logic [3:0] IDX_HOURS_COUNT = 4'h2;
    localparam logic [3:0] IDX_WEEKDAY_COUNT = 4'h3;
    localparam logic [3:0] IDX_DATE_COUNT = 4'h4;
    localparam logic [3:0] IDX_ALARM_MINUTE = 4'h8;
    localparam logic [3:0] IDX_ALARM_HOUR = 4'h9;
    localparam logic [3:0] IDX_ALARM_WEEKDAY_OR_DATE = 4'ha;
    localparam logic [3:0] IDX_EXTENSION_CONFIG = 4'hd;
    localparam logic [3:0] IDX_EVENT_FLAGS = 4'he;
    localparam logic [3:0] IDX_INTERRUPT_CONTROL = 4'hf;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int BIT_ALARM_COMPARE_DISABLE = 7;
    localparam int BIT_WEEK_OR_DATE_SELECT = 6;
    localparam int BIT_UPDATE_PERIOD_SELECT = 5;
    localparam int BIT_UPDATE_EVENT_FLAG = 5;
    localparam int BIT_ALARM_EVENT_FLAG = 3;
    localparam int BIT_UPDATE_IRQ_ENABLE = 5;
    localparam int BIT_ALARM_IRQ_ENABLE = 3;
    localparam int BIT_CTRL_RESET = 0;
    // Writable bits of the control register; the rest read zero
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hf9;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic [7:0] ALARM_RESET_VALUE = 8'h00;
    localparam logic [7:0] EXTENSION_RESET_VALUE = 8'h00;
    localparam logic [7:0] CONTROL_RESET_VALUE = 8'h00;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned PCLK_PERIOD_NS = 10;
    localparam int unsigned INT_RELEASE_US = 7800;
    // Longest time, so the count rounds down
    localparam int unsigned INT_RELEASE_CYCLES =
        (INT_RELEASE_US * 1000) / PCLK_PERIOD_NS;

    // ==========================================================
    // Carrier types
    // ==========================================================
    // Running time from the clock counters, BCD coded
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [6:0] weekday;
        logic [5:0] date;
    } rtcu_time_t;

    // Advance strobes from the clock counters
    typedef struct packed {
        logic second_tick;
        logic minute_tick;
    } rtcu_tick_t;

endpackage

/* File: verif/rtcu_time_model.sv */
// Behavioural model of the clock counters ahead of the interrupt block
`timescale 1ns/1ps
module rtcu_time_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic adv,
    input wire logic ld,
    input wire rtcu_pkg::rtcu_time_t ld_time,
    input wire logic [5:0] ld_sec,
    output rtcu_pkg::rtcu_time_t time_now,
    output rtcu_pkg::rtcu_tick_t time_tick
);
    import rtcu_pkg::*;
    logic [5:0] sec_reg;
    function automatic logic [6:0] next_min(input logic [6:0] m);
        if (m[3:0] != 4'h9) return m + 7'h01;
        return (m == 7'h59) ? 7'h00 : {m[6:4] + 3'h1, 4'h0};
    endfunction
    // ==========================================================
    // Counting: a new time and its tick show in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_reg <= 6'h00;
            time_now <= '0;
            time_tick <= '0;
        end else begin
            time_tick <= '0;
            if (ld) begin
                time_now <= ld_time;
                sec_reg <= ld_sec;
            end else if (adv) begin
                time_tick <= {1'b1, sec_reg == 6'h3b};
                sec_reg <= (sec_reg == 6'h3b) ? 6'h00 : sec_reg + 6'h01;
                if (sec_reg == 6'h3b) begin
                    time_now.minute <= next_min(time_now.minute);
                end
            end
        end
    end
endmodule

/* File: verif/rtcu_irq_chk.sv */
// Port-level checker of the update and alarm interrupt block
`timescale 1ns/1ps
module rtcu_irq_chk #(
    parameter int unsigned ADDR_WIDTH = 12,
    parameter int unsigned RELEASE_CYCLES = rtcu_pkg::INT_RELEASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire rtcu_pkg::rtcu_time_t time_now,
    input wire rtcu_pkg::rtcu_tick_t time_tick,
    input wire logic int_o,
    input wire logic int_oe_n
);
    import rtcu_pkg::*;
    localparam logic [ADDR_WIDTH-1:0] A_FLG = ADDR_WIDTH'(8'h38);
    localparam logic [ADDR_WIDTH-1:0] A_CTL = ADDR_WIDTH'(8'h3c);
    logic wr;
    logic wr_q;
    logic [7:0] ctl_reg;
    logic [31:0] low_cnt;
    assign wr = psel && penable && pready && pwrite && pstrb[0];
    // ==========================================================
    // Shadow of the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= 1'b0;
            ctl_reg <= 8'h00;
        end else begin
            wr_q <= wr;
            if (wr && paddr == A_CTL) begin
                ctl_reg <= pwdata[7:0];
            end
        end
    end
    // ==========================================================
    // Length of a low spell since the last second or minute tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 32'h0;
        end else if (int_oe_n || ctl_reg[3] || time_tick != 2'h0) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ctl_wr;
        wr && paddr == A_CTL;
    endsequence
    sequence s_read(a);
        pready && !pwrite && paddr == a;
    endsequence
    sequence s_low2;
        ##2 !int_oe_n;
    endsequence
    a_pin_data: assert property (int_o == 1'b0)
        else $error("pin data not low");
    a_upd_assert: assert property (time_tick.minute_tick && ctl_reg[5]
        && !ctl_reg[0] |-> s_low2) else $error("update low missing");
    a_upd_timeout: assert property (!ctl_reg[3]
        |-> low_cnt <= RELEASE_CYCLES + 2) else $error("update low too long");
    a_en_release: assert property (s_ctl_wr ##0 !pwdata[5] && !pwdata[3]
        |-> ##2 int_oe_n) else $error("pin not released");
    a_flag_keep: assert property (wr && paddr == A_FLG && !int_oe_n
        && ctl_reg[5:3] == 3'h4 && low_cnt < 8 |-> s_low2)
        else $error("flag clear released pin");
    a_alarm_hold: assert property (!int_oe_n && ctl_reg[3] && !ctl_reg[5]
        && !wr && !wr_q |=> !int_oe_n) else $error("alarm low dropped");
    a_reset_quiet: assert property (time_tick.minute_tick && ctl_reg[0]
        && int_oe_n |-> ##1 int_oe_n [*2]) else $error("event under reset");
    a_flag_zero: assert property (s_read(A_FLG)
        |-> (prdata & 32'hffff_ffd7) == 32'h0) else $error("flag bits");
    a_ctl_zero: assert property (s_read(A_CTL)
        |-> prdata[31:8] == 24'h0 && prdata[2:1] == 2'h0)
        else $error("control bits");
endmodule

bind rtcu_irq rtcu_irq_chk #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .RELEASE_CYCLES(RELEASE_CYCLES)
) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .time_now, .time_tick, .int_o,
    .int_oe_n);

/* File: verif/rtcu_irq_tb_top.sv */
// Self-checking bench of the update and alarm interrupt block
`timescale 1ns/1ps
module rtcu_irq_tb_top;
    import rtcu_pkg::*;
    localparam int unsigned RC = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adv = 1'b0;
    logic ld = 1'b0;
    rtcu_time_t ld_time = '0;
    logic [5:0] ld_sec = 6'h00;
    rtcu_time_t time_now;
    rtcu_tick_t time_tick;
    logic int_o;
    logic int_oe_n;
    int fail_count = 0;
    int n_compared = 0;
    logic [33:0] exp_q[$];
    logic [33:0] got_e;
    logic [7:0] rnd;
    // Alarm table: expect, minute, hour, day, extension
    logic [32:0] rows[8] = '{33'h1_3047_0c00, 33'h0_3007_0300,
        33'h1_3007_5540, 33'h0_3007_1640, 33'h0_3107_0c00,
        33'h1_8007_0c00, 33'h0_3008_0c00, 33'h1_8080_8000};

    always #5 pclk = ~pclk;

    rtcu_irq #(.ADDR_WIDTH(12), .RELEASE_CYCLES(RC)) dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .time_now, .time_tick, .int_o, .int_oe_n);
    rtcu_time_model u_time (.pclk, .presetn, .adv, .ld, .ld_time, .ld_sec,
        .time_now, .time_tick);

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pin(input logic e);
        cmp("int_oe_n", {31'h0, e}, {31'h0, int_oe_n});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic tick();
        @(posedge pclk);
        adv <= 1'b1;
        @(posedge pclk);
        adv <= 1'b0;
    endtask
    task automatic load(input logic [6:0] m, input logic [5:0] s);
        @(posedge pclk);
        ld_time <= {m, 6'h07, 7'h04, 6'h15};
        ld_sec <= s;
        ld <= 1'b1;
        @(posedge pclk);
        ld <= 1'b0;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d, input logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        exp_q.push_back({w, err, 24'h0, err ? 8'h00 : d});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            cmp("pready", 32'h1, 32'h0);
            end_of_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, d, 1'b0);
    endtask

    // ==========================================================
    // Answer watcher: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("spare_ready", 32'h0, 32'h1);
            end else begin
                got_e = exp_q.pop_front();
                cmp("pslverr", {31'h0, got_e[32]}, {31'h0, pslverr});
                if (!got_e[33]) begin
                    cmp("prdata", got_e[31:0], prdata);
                end
            end
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(83903));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'h020 + 12'(i * 4), 8'h00, i == 3 || i == 4);
        end
        apb(1'b1, 12'h022, 8'h55, 1'b1);
        load(7'h42, 6'h0a);
        wr(12'h004, 8'h11);
        rd(12'h004, 8'h42);
        wr(12'h03c, 8'hff);
        rd(12'h03c, 8'hf9);
        pstrb <= 4'he;
        wr(12'h03c, 8'h00);
        pstrb <= 4'hf;
        rd(12'h03c, 8'hf9);
        wr(12'h03c, 8'h20);
        tick();
        cyc(3);
        pin(1'b0);
        wr(12'h038, 8'h00);
        cyc(2);
        pin(1'b0);
        rd(12'h038, 8'h00);
        cyc(RC);
        pin(1'b1);
        tick();
        cyc(3);
        rd(12'h038, 8'h20);
        wr(12'h038, 8'hff);
        rd(12'h038, 8'h20);
        wr(12'h03c, 8'h00);
        cyc(2);
        pin(1'b1);
        wr(12'h038, 8'h00);
        wr(12'h034, 8'h20);
        tick();
        rd(12'h038, 8'h00);
        load(7'h10, 6'h3b);
        tick();
        rd(12'h038, 8'h20);
        wr(12'h038, 8'h00);
        foreach (rows[i]) begin
            wr(12'h03c, 8'h00);
            load(7'h30, 6'h0a);
            wr(12'h020, rows[i][31:24]);
            wr(12'h024, rows[i][23:16]);
            wr(12'h028, rows[i][15:8]);
            wr(12'h034, rows[i][7:0]);
            wr(12'h03c, 8'h08);
            rd(12'h038, 8'h00);
            load(7'h29, 6'h3b);
            tick();
            cyc(3);
            pin(~rows[i][32]);
            rd(12'h038, {4'h2, rows[i][32], 3'h0});
            if (rows[i][32]) begin
                cyc(RC);
                pin(1'b0);
                wr(i[0] ? 12'h038 : 12'h03c, 8'h00);
                cyc(2);
                pin(1'b1);
            end
            wr(12'h038, 8'h00);
        end
        wr(12'h03c, 8'h29);
        load(7'h29, 6'h3b);
        tick();
        cyc(3);
        pin(1'b1);
        rd(12'h038, 8'h00);
        wr(12'h03c, 8'h28);
        load(7'h29, 6'h3b);
        tick();
        cyc(RC + 4);
        pin(1'b0);
        wr(12'h03c, 8'h20);
        cyc(2);
        pin(1'b1);
        wr(12'h03c, 8'h00);
        wr(12'h038, 8'h00);
        load(7'h29, 6'h3b);
        tick();
        cyc(3);
        pin(1'b1);
        rd(12'h038, 8'h28);
        for (int i = 0; i < 3; i++) begin
            rnd = 8'($urandom);
            wr(12'h020 + 12'(i * 4), rnd);
            rd(12'h020 + 12'(i * 4), rnd);
        end
        cyc(4);
        end_of_test();
    end
endmodule
